/* File: jtb_pkg.sv */
// jtb_pkg: shared types and constants of the boundary-scan test port.
// assumes: nothing beyond a SystemVerilog compiler.
package jtb_pkg;

  // ---------------------------------------------------------------
  // controller states and data paths
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } jtb_state_t;

  typedef enum logic [1:0] {PATH_BYP, PATH_ID, PATH_BSR} jtb_path_t;

  // test pins as they arrive, and their idle values
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jtb_pins_t;

  localparam jtb_pins_t PINS_IDLE = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};

  // ---------------------------------------------------------------
  // instruction register
  // ---------------------------------------------------------------
  localparam int        IR_W       = 4;
  localparam logic [3:0] IR_EXTEST  = 4'h0;
  localparam logic [3:0] IR_SAMPLE  = 4'h1;
  localparam logic [3:0] IR_IDCODE  = 4'h2;
  localparam logic [3:0] IR_HIZ     = 4'h3;
  localparam logic [3:0] IR_BYPASS  = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // ---------------------------------------------------------------
  // identification word layout
  // ---------------------------------------------------------------
  localparam int         ID_W        = 32;
  localparam int         ID_VER_LSB  = 28;
  localparam int         ID_PART_LSB = 12;
  localparam int         ID_MFR_LSB  = 1;
  localparam logic [0:0] ID_MARK     = 1'h1;

  // tap reset tms count
  localparam logic [2:0] TMS_RESET_CNT = 3'h5;

endpackage

/* File: jtb_sync.sv */
// jtb_sync: two-stage synchroniser for a group of asynchronous inputs.
// assumes: inputs change independently of clk; only the second stage is read.
`timescale 1ns/100ps
module jtb_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } jtb_sync_t;

  jtb_sync_t r_reg;
  jtb_sync_t r_next;

  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '{s1: RST, s2: RST};
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;

endmodule

/* File: jtb_tap_top.sv */
// jtb_tap_top: boundary-scan test access port of the memory buffer.
// assumes: test pins and PIN_IN are asynchronous to CORE_CLK and are
// synchronised here; CORE_OUT and CORE_OE come from core logic on CORE_CLK.
// test clock must run far slower than CORE_CLK (edges found by sampling).
`timescale 1ns/100ps
module jtb_tap_top #(
  parameter int           N_IN     = 8,
  parameter int           N_OUT    = 8,
  parameter logic [3:0]   ID_VER   = 4'h1,     // arbitrary value
  parameter logic [15:0]  ID_PART  = 16'h0a1c, // arbitrary value
  parameter logic [10:0]  ID_MFR   = 11'h12d   // arbitrary value
) (
  input  wire logic             CORE_CLK,
  input  wire logic             NRST,
  input  wire logic             TCK,
  input  wire logic             TMS,
  input  wire logic             TDI,
  input  wire logic             TRST_N,
  output logic                  TDO,
  output logic                  TDO_OE,
  input  wire logic [N_IN-1:0]  PIN_IN,
  output logic      [N_IN-1:0]  CORE_IN,
  input  wire logic [N_OUT-1:0] CORE_OUT,
  input  wire logic             CORE_OE,
  output logic      [N_OUT-1:0] PIN_OUT,
  output logic                  PIN_OE,
  output logic                  TAP_READY
);

  // ---------------------------------------------------------------
  // boundary layout: inputs low, outputs above, enable cell on top
  // ---------------------------------------------------------------
  localparam int BSR_L  = N_IN + N_OUT + 1;
  localparam int OUT_LO = N_IN;
  localparam int OE_BIT = BSR_L - 1;

  typedef struct packed {
    jtb_pkg::jtb_state_t state;
    logic                tck_d;
    logic [3:0]          ir_sh;
    logic [3:0]          ir;
    logic                byp;
    logic [31:0]         id_sh;
    logic [BSR_L-1:0]    bsr_sh;
    logic [BSR_L-1:0]    bsr_up;
    logic                tdo;
    logic                tdo_oe;
    logic [N_OUT-1:0]    pin_out;
    logic                pin_oe;
    logic [N_IN-1:0]     core_in;
    logic                ready;
  } jtb_core_t;

  jtb_core_t r_reg;
  jtb_core_t r_next;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  jtb_pkg::jtb_pins_t pins_s;
  logic [3:0]         pins_q;
  logic [N_IN-1:0]    pin_s;

  jtb_sync #(
    .W   (4),
    .RST (jtb_pkg::PINS_IDLE)
  ) u_test_sync (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .d     ({TCK, TMS, TDI, TRST_N}),
    .q     (pins_q)
  );

  jtb_sync #(
    .W   (N_IN),
    .RST ('0)
  ) u_pin_sync (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .d     (PIN_IN),
    .q     (pin_s)
  );

  assign pins_s = jtb_pkg::jtb_pins_t'(pins_q);

  logic tck_rise;
  logic tck_fall;
  assign tck_rise = pins_s.tck & ~r_reg.tck_d;
  assign tck_fall = ~pins_s.tck & r_reg.tck_d;

  // ---------------------------------------------------------------
  // controller next state
  // ---------------------------------------------------------------
  function automatic jtb_pkg::jtb_state_t next_st(input jtb_pkg::jtb_state_t s, input logic tms);
    jtb_pkg::jtb_state_t n;
    n = s;
    unique case (s)
      jtb_pkg::ST_RESET:  n = tms ? jtb_pkg::ST_RESET  : jtb_pkg::ST_IDLE;
      jtb_pkg::ST_IDLE:   n = tms ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_IDLE;
      jtb_pkg::ST_SEL_DR: n = tms ? jtb_pkg::ST_SEL_IR : jtb_pkg::ST_CAP_DR;
      jtb_pkg::ST_CAP_DR: n = tms ? jtb_pkg::ST_EX1_DR : jtb_pkg::ST_SH_DR;
      jtb_pkg::ST_SH_DR:  n = tms ? jtb_pkg::ST_EX1_DR : jtb_pkg::ST_SH_DR;
      jtb_pkg::ST_EX1_DR: n = tms ? jtb_pkg::ST_UPD_DR : jtb_pkg::ST_PAU_DR;
      jtb_pkg::ST_PAU_DR: n = tms ? jtb_pkg::ST_EX2_DR : jtb_pkg::ST_PAU_DR;
      jtb_pkg::ST_EX2_DR: n = tms ? jtb_pkg::ST_UPD_DR : jtb_pkg::ST_SH_DR;
      jtb_pkg::ST_UPD_DR: n = tms ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_IDLE;
      jtb_pkg::ST_SEL_IR: n = tms ? jtb_pkg::ST_RESET  : jtb_pkg::ST_CAP_IR;
      jtb_pkg::ST_CAP_IR: n = tms ? jtb_pkg::ST_EX1_IR : jtb_pkg::ST_SH_IR;
      jtb_pkg::ST_SH_IR:  n = tms ? jtb_pkg::ST_EX1_IR : jtb_pkg::ST_SH_IR;
      jtb_pkg::ST_EX1_IR: n = tms ? jtb_pkg::ST_UPD_IR : jtb_pkg::ST_PAU_IR;
      jtb_pkg::ST_PAU_IR: n = tms ? jtb_pkg::ST_EX2_IR : jtb_pkg::ST_PAU_IR;
      jtb_pkg::ST_EX2_IR: n = tms ? jtb_pkg::ST_UPD_IR : jtb_pkg::ST_SH_IR;
      jtb_pkg::ST_UPD_IR: n = tms ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_IDLE;
    endcase
    return n;
  endfunction

  // ---------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------
  jtb_pkg::jtb_path_t sel;
  logic               extest;
  logic               hiz;
  logic               dr_lsb;

  always_comb begin
    unique case (r_reg.ir)
      jtb_pkg::IR_EXTEST: sel = jtb_pkg::PATH_BSR;
      jtb_pkg::IR_SAMPLE: sel = jtb_pkg::PATH_BSR;
      jtb_pkg::IR_IDCODE: sel = jtb_pkg::PATH_ID;
      default:            sel = jtb_pkg::PATH_BYP;
    endcase
  end

  assign extest = (r_reg.ir == jtb_pkg::IR_EXTEST);
  assign hiz    = (r_reg.ir == jtb_pkg::IR_HIZ);

  always_comb begin
    unique case (sel)
      jtb_pkg::PATH_BSR: dr_lsb = r_reg.bsr_sh[0];
      jtb_pkg::PATH_ID:  dr_lsb = r_reg.id_sh[0];
      jtb_pkg::PATH_BYP: dr_lsb = r_reg.byp;
      default:           dr_lsb = r_reg.byp;
    endcase
  end

  logic [31:0] id_word;
  assign id_word = {ID_VER, ID_PART, ID_MFR, jtb_pkg::ID_MARK};

  // ---------------------------------------------------------------
  // register update
  // ---------------------------------------------------------------
  always_comb begin
    r_next       = r_reg;
    r_next.tck_d = pins_s.tck;
    if (tck_rise) begin
      r_next.state = next_st(r_reg.state, pins_s.tms);
      if (r_reg.state == jtb_pkg::ST_RESET) begin
        r_next.ir = jtb_pkg::IR_IDCODE;
      end
      if (r_reg.state == jtb_pkg::ST_CAP_IR) begin
        r_next.ir_sh = jtb_pkg::IR_CAPTURE;
      end
      if (r_reg.state == jtb_pkg::ST_SH_IR) begin
        r_next.ir_sh = {pins_s.tdi, r_reg.ir_sh[3:1]};
      end
      if (r_reg.state == jtb_pkg::ST_UPD_IR) begin
        r_next.ir = r_reg.ir_sh;
      end
      // only the selected register moves; the rest hold
      if (r_reg.state == jtb_pkg::ST_CAP_DR) begin
        unique case (sel)
          jtb_pkg::PATH_BYP: r_next.byp = 1'b0;
          jtb_pkg::PATH_ID:  r_next.id_sh = id_word;
          jtb_pkg::PATH_BSR: r_next.bsr_sh = {CORE_OE, CORE_OUT, pin_s};
        endcase
      end
      if (r_reg.state == jtb_pkg::ST_SH_DR) begin
        unique case (sel)
          jtb_pkg::PATH_BYP: r_next.byp = pins_s.tdi;
          jtb_pkg::PATH_ID:  r_next.id_sh = {pins_s.tdi, r_reg.id_sh[31:1]};
          jtb_pkg::PATH_BSR: r_next.bsr_sh = {pins_s.tdi, r_reg.bsr_sh[BSR_L-1:1]};
        endcase
      end
      if (r_reg.state == jtb_pkg::ST_UPD_DR && sel == jtb_pkg::PATH_BSR) begin
        r_next.bsr_up = r_reg.bsr_sh;
      end
      // exit and pause states touch no register
    end
    if (tck_fall) begin
      // output changes on the falling edge so the tester samples a settled bit
      r_next.tdo    = (r_reg.state == jtb_pkg::ST_SH_DR) ? dr_lsb : r_reg.ir_sh[0];
      r_next.tdo_oe = (r_reg.state == jtb_pkg::ST_SH_DR) || (r_reg.state == jtb_pkg::ST_SH_IR);
    end
    if (!pins_s.trst_n) begin
      r_next.state = jtb_pkg::ST_RESET;
      r_next.ir    = jtb_pkg::IR_IDCODE;
    end
    // core may use the memory only after a tap reset has been seen
    r_next.ready   = r_reg.ready | (r_next.state == jtb_pkg::ST_RESET);
    r_next.pin_out = extest ? r_reg.bsr_up[OE_BIT-1:OUT_LO] : CORE_OUT;
    r_next.pin_oe  = hiz ? 1'b0 : (extest ? r_reg.bsr_up[OE_BIT] : CORE_OE);
    r_next.core_in = extest ? r_reg.bsr_up[N_IN-1:0] : pin_s;
  end

  // no tap reset on power-up: core reset parks the controller in idle and loads IR_IDCODE into the instruction register
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      r_reg         <= '0;
      r_reg.state   <= jtb_pkg::ST_IDLE;
      r_reg.ir      <= jtb_pkg::IR_IDCODE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign TDO       = r_reg.tdo;
  assign TDO_OE    = r_reg.tdo_oe;
  assign PIN_OUT   = r_reg.pin_out;
  assign PIN_OE    = r_reg.pin_oe;
  assign CORE_IN   = r_reg.core_in;
  assign TAP_READY = r_reg.ready;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [2:0] tms_cnt_reg;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      tms_cnt_reg <= 3'h0;
    end else if (tck_rise) begin
      if (!pins_s.tms) begin
        tms_cnt_reg <= 3'h0;
      end else if (tms_cnt_reg != jtb_pkg::TMS_RESET_CNT) begin
        tms_cnt_reg <= tms_cnt_reg + 3'h1;
      end
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);

  state_on_rise_a: assert property ((!tck_rise && pins_s.trst_n) |=> $stable(r_reg.state))
    else $error("tap state moved without a test clock rise");

  tms_reset_a: assert property ((tms_cnt_reg == jtb_pkg::TMS_RESET_CNT) |-> r_reg.state == jtb_pkg::ST_RESET)
    else $error("five tms-high rises did not reach reset");

  trst_force_a: assert property (!pins_s.trst_n |=> (r_reg.state == jtb_pkg::ST_RESET && r_reg.ir == jtb_pkg::IR_IDCODE))
    else $error("test reset did not force reset and identify");

  ir_hold_a: assert property ((!(tck_rise && r_reg.state inside {jtb_pkg::ST_UPD_IR, jtb_pkg::ST_RESET})
    && pins_s.trst_n) |=> $stable(r_reg.ir))
    else $error("instruction changed outside update");

  ir_shift_a: assert property ((tck_rise && r_reg.state == jtb_pkg::ST_SH_IR) |=> r_reg.ir_sh[3] == $past(pins_s.tdi))
    else $error("instruction bit not shifted in at msb");

  bypass_clear_a: assert property ((tck_rise && r_reg.state == jtb_pkg::ST_CAP_DR && sel == jtb_pkg::PATH_BYP)
    ##1 (!tck_rise)[*2] |-> !r_reg.byp)
    else $error("bypass stage not cleared on capture");

  dr_pause_a: assert property ((tck_rise && r_reg.state inside {jtb_pkg::ST_PAU_DR, jtb_pkg::ST_EX1_DR,
    jtb_pkg::ST_EX2_DR}) |=> ($stable(r_reg.bsr_sh) && $stable(r_reg.id_sh) && $stable(r_reg.byp)))
    else $error("data register moved in exit or pause");

  tdo_fall_a: assert property ((tck_fall && r_reg.state == jtb_pkg::ST_SH_DR) |=> (TDO_OE && TDO == $past(dr_lsb)))
    else $error("serial output not driven on falling edge");

  hiz_pins_a: assert property ((hiz && $stable(r_reg.ir)) |=> !PIN_OE)
    else $error("outputs driven under high-impedance code");

  id_mark_a: assert property ((tck_rise && r_reg.state == jtb_pkg::ST_CAP_DR && sel == jtb_pkg::PATH_ID)
    |=> r_reg.id_sh == id_word && r_reg.id_sh[0])
    else $error("identity word not captured");

  // ---------------------------------------------------------------
  // pin path and register update checks
  // ---------------------------------------------------------------
  ir_capture_a: assert property ((tck_rise && r_reg.state == jtb_pkg::ST_CAP_IR)
    |=> r_reg.ir_sh == jtb_pkg::IR_CAPTURE)
    else $error("capture-ir did not load the fixed pattern");

  ir_update_a: assert property ((tck_rise && r_reg.state == jtb_pkg::ST_UPD_IR && pins_s.trst_n)
    |=> r_reg.ir == $past(r_reg.ir_sh))
    else $error("update-ir did not latch the shifted instruction");

  bsr_capture_a: assert property ((tck_rise && r_reg.state == jtb_pkg::ST_CAP_DR
    && sel == jtb_pkg::PATH_BSR) |=> r_reg.bsr_sh == $past({CORE_OE, CORE_OUT, pin_s}))
    else $error("boundary cells did not capture pin and core values");

  bsr_shift_a: assert property ((tck_rise && r_reg.state == jtb_pkg::ST_SH_DR
    && sel == jtb_pkg::PATH_BSR) |=> (r_reg.bsr_sh[BSR_L-1] == $past(pins_s.tdi)
    && r_reg.bsr_sh[BSR_L-2:0] == $past(r_reg.bsr_sh[BSR_L-1:1])))
    else $error("boundary cells did not shift toward the output");

  upd_latch_a: assert property ((tck_rise && r_reg.state == jtb_pkg::ST_UPD_DR
    && sel == jtb_pkg::PATH_BSR) |=> r_reg.bsr_up == $past(r_reg.bsr_sh))
    else $error("update-dr did not latch the boundary cells");

  extest_pins_a: assert property (extest |=> (PIN_OUT == $past(r_reg.bsr_up[OE_BIT-1:OUT_LO])
    && PIN_OE == $past(r_reg.bsr_up[OE_BIT]) && CORE_IN == $past(r_reg.bsr_up[N_IN-1:0])))
    else $error("external test did not drive pins from update cells");

  core_pins_a: assert property ((!extest && !hiz) |=> (PIN_OUT == $past(CORE_OUT)
    && PIN_OE == $past(CORE_OE) && CORE_IN == $past(pin_s)))
    else $error("test logic disturbed the normal pin path");

  tdo_release_a: assert property ((tck_fall && !(r_reg.state inside {jtb_pkg::ST_SH_DR, jtb_pkg::ST_SH_IR}))
    |=> !TDO_OE)
    else $error("serial output driven outside a shift state");

  bypass_shift_a: assert property ((tck_rise && r_reg.state == jtb_pkg::ST_SH_DR
    && sel == jtb_pkg::PATH_BYP) |=> r_reg.byp == $past(pins_s.tdi))
    else $error("bypass stage did not take the serial input");

endmodule

/* File: jtb_tester.sv */
// jtb_tester: behavioural test controller that drives the test pins of the port.
// assumes: the port samples these pins with a clock far faster than the 80 ns test clock.
`timescale 1ns/100ps
module jtb_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  input  wire logic tdo
);
  logic tgl;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
    tgl = 1'b0;
  end

  // ---------------------------------------------------------------
  // link cycles
  // ---------------------------------------------------------------
  // pins move with the fall; tdo is read mid-high, where it still holds the last fall's bit
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #40 tck = 1'b1;
    #20 o = tdo;
    #20 tck = 1'b0;
  endtask

  // serial input toggles when not shifting, so a stray shift shows up
  task automatic idle(input logic m);
    logic o;
    step(m, tgl, o);
    tgl = ~tgl;
  endtask

  task automatic reset_tms();
    repeat (5) idle(1'b1);
    idle(1'b0);
  endtask

  task automatic pulse_trst();
    trst_n = 1'b0;
    #60 trst_n = 1'b1;
    #60;
    idle(1'b0);
  endtask

  task automatic scan_ir(input logic [3:0] code, output logic [3:0] cap);
    idle(1'b1);
    idle(1'b1);
    idle(1'b0);
    idle(1'b0);
    for (int i = 0; i < 4; i++) step(i == 3, code[i], cap[i]);
    idle(1'b1);
    idle(1'b0);
  endtask

  // pz > 0 leaves shifting after bit pz-1 and parks in pause before going on
  task automatic scan_dr(input int n, input logic [31:0] din, input int pz, output logic [31:0] dout);
    logic b;
    dout = '0;
    idle(1'b1);
    idle(1'b0);
    idle(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == pz - 1, din[i], b);
      dout[i] = b;
      if (i == pz - 1) begin
        idle(1'b0);
        idle(1'b0);
        idle(1'b1);
        idle(1'b0);
      end
    end
    idle(1'b1);
    idle(1'b0);
  endtask
endmodule

/* File: jtb_tap_top_tb.sv */
// jtb_tap_top_tb: self-checking bench of the boundary-scan test port.
// assumes: jtb_pkg, jtb_tap_top and jtb_tester are compiled first.
`timescale 1ns/100ps
module jtb_tap_top_tb;
  localparam logic [3:0]  VER  = 4'h6;     // arbitrary value
  localparam logic [15:0] PART = 16'h2c47; // arbitrary value
  localparam logic [10:0] MFR  = 11'h0e9;  // arbitrary value
  localparam logic [31:0] IDW  = {VER, PART, MFR, jtb_pkg::ID_MARK};

  // drive word is {CORE_OE, CORE_OUT, PIN_IN}; pins word is {PIN_OE, PIN_OUT, CORE_IN}
  typedef struct packed {
    logic [3:0]  code;
    logic [16:0] drive;
    logic [31:0] len;
    logic [31:0] din;
    logic [31:0] dmask;
    logic [31:0] dexp;
    logic [16:0] pexp;
    logic [16:0] pmask;
  } jtb_row_t;

  localparam jtb_row_t ROWS [7] = '{
    '{4'hf, 17'h1c35a, 8, 32'hb4, 32'hff, 32'h68, 17'h1c35a, 17'h1ffff},
    '{4'h7, 17'h03ca5, 8, 32'h5b, 32'hff, 32'hb6, 17'h03ca5, 17'h1ffff},
    '{4'h3, 17'h196e1, 8, 32'h96, 32'hff, 32'h2c, 17'h096e1, 17'h100ff},
    '{4'h2, 17'h15ac3, 32, 32'h0, 32'hffffffff, IDW, 17'h15ac3, 17'h1ffff},
    '{4'h1, 17'h0e718, 17, 32'h13c96, 32'h1ffff, 32'h0e718, 17'h0e718, 17'h1ffff},
    '{4'h0, 17'h05ac3, 17, 32'h1e12d, 32'h1ffff, 32'h05ac3, 17'h1e12d, 17'h1ffff},
    '{4'hf, 17'h1c35a, 8, 32'hb4, 32'hff, 32'h68, 17'h1c35a, 17'h1ffff}
  };

  logic        core_clk;
  logic        nrst;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        trst_n;
  logic        tdo_q;
  logic        tdo_oe;
  wire         tdo_line;
  logic [7:0]  pin_in;
  logic [7:0]  core_in;
  logic [7:0]  core_out;
  logic        core_oe;
  logic [7:0]  pin_out;
  logic        pin_oe;
  logic        tap_ready;
  logic [3:0]  cap;
  logic [31:0] dout;
  logic        b;
  int          n_errors = 0;
  int          n_checks = 0;

  // a released serial output floats, so reading it outside a shift fails the compare
  assign tdo_line = tdo_oe ? tdo_q : 1'bz;

  jtb_tester tst (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo_line));

  jtb_tap_top #(.ID_VER(VER), .ID_PART(PART), .ID_MFR(MFR)) dut (
    .CORE_CLK(core_clk), .NRST(nrst), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_N(trst_n),
    .TDO(tdo_q), .TDO_OE(tdo_oe), .PIN_IN(pin_in), .CORE_IN(core_in), .CORE_OUT(core_out),
    .CORE_OE(core_oe), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .TAP_READY(tap_ready)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // compare and verdict
  // ---------------------------------------------------------------
  task automatic check_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    n_errors++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    core_out = 8'hc3;
    core_oe = 1'b1;
    pin_in = 8'h5a;
    repeat (20) @(posedge core_clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge core_clk);
    // test pins move 1 ns after a core edge so the synchronisers never race them
    #1;
    check_vec("ready before tap reset", 32'h0, {31'h0, tap_ready});
    tst.reset_tms();
    check_vec("ready after tms reset", 32'h1, {31'h0, tap_ready});
    foreach (ROWS[k]) begin
      {core_oe, core_out, pin_in} = ROWS[k].drive;
      tst.scan_ir(ROWS[k].code, cap);
      check_vec("captured instruction", {28'h0, jtb_pkg::IR_CAPTURE}, {28'h0, cap});
      tst.scan_dr(ROWS[k].len, ROWS[k].din, 0, dout);
      check_vec("scanned data", ROWS[k].dexp & ROWS[k].dmask, dout & ROWS[k].dmask);
      check_vec("pin outputs", {15'h0, ROWS[k].pexp & ROWS[k].pmask},
                {15'h0, {pin_oe, pin_out, core_in} & ROWS[k].pmask});
      check_vec("serial output enable idle", 32'h0, {31'h0, tdo_oe});
    end
    // leave shifting half way by mode-select reset, then read identity through a pause
    tst.idle(1'b1);
    tst.idle(1'b0);
    tst.idle(1'b0);
    tst.reset_tms();
    tst.scan_dr(32, 32'h0, 5, dout);
    check_vec("identity after paused scan", IDW, dout);
    // test reset in the middle of a data shift
    tst.scan_ir(4'hf, cap);
    tst.idle(1'b1);
    tst.idle(1'b0);
    tst.idle(1'b0);
    tst.pulse_trst();
    tst.scan_dr(32, 32'hffffffff, 0, dout);
    check_vec("identity after test reset", IDW, dout);
    // float instruction shifted in but held in pause: pins must still drive
    tst.idle(1'b1);
    tst.idle(1'b1);
    tst.idle(1'b0);
    tst.idle(1'b0);
    for (int i = 0; i < 4; i++) tst.step(i == 3, i < 2, b);
    tst.idle(1'b0);
    check_vec("pin enable before update", 32'h1, {31'h0, pin_oe});
    tst.idle(1'b1);
    tst.idle(1'b1);
    tst.idle(1'b0);
    check_vec("pin enable after update", 32'h0, {31'h0, pin_oe});
    complete_run();
  end
endmodule
